// file: inc/ssc_pkg.sv
// constants for the sound-sync control register bank
// assumes a 25 MHz system clock and an 8-bit internal register port
package ssc_pkg;

  // register offsets on the control port
  localparam logic [7:0] SSC_GAIN_CTRL_OFS  = 8'h40;
  localparam logic [7:0] SSC_IN_BUF_OFS     = 8'h41;
  localparam logic [7:0] SSC_SND_CTRL_OFS   = 8'h42;
  localparam logic [7:0] SSC_OUT_SEL_OFS    = 8'h43;

  // reset values
  localparam logic [7:0] SSC_GAIN_CTRL_RST  = 8'h00;
  localparam logic [7:0] SSC_IN_BUF_RST     = 8'h00;
  localparam logic [7:0] SSC_SND_CTRL_RST   = 8'h00;
  localparam logic [7:0] SSC_OUT_SEL_RST    = 8'h00;

  // writable bit masks, undefined bits stay zero
  localparam logic [7:0] SSC_GAIN_CTRL_MASK = 8'h7f;
  localparam logic [7:0] SSC_IN_BUF_MASK    = 8'hff;
  localparam logic [7:0] SSC_SND_CTRL_MASK  = 8'hdf;
  localparam logic [7:0] SSC_OUT_SEL_MASK   = 8'h0f;

  // field positions
  localparam int SSC_AGC_EN_BIT      = 0;
  localparam int SSC_RISE_LSB        = 1;
  localparam int SSC_FALL_LSB        = 3;
  localparam int SSC_LOWER_HI_BIT    = 5;
  localparam int SSC_RAISE_HI_BIT    = 6;
  localparam int SSC_BUF_PWR_BIT     = 0;
  localparam int SSC_GAIN_LSB        = 1;
  localparam int SSC_PRE_MAN_BIT     = 6;
  localparam int SSC_PRE_INH_BIT     = 7;
  localparam int SSC_EFFECT_LSB      = 0;
  localparam int SSC_DECAY_LSB       = 3;
  localparam int SSC_PD_DIS_BIT      = 6;
  localparam int SSC_SRC_SEL_BIT     = 7;

  // automatic gain window around the programmed gain
  localparam logic signed [2:0] SSC_AGC_SPAN = 3'sd3;
  localparam logic [4:0]        SSC_GAIN_MAX = 5'h1f;

  // clock and times
  localparam int unsigned SSC_CLK_HZ        = 25_000_000;
  localparam int unsigned SSC_CYC_PER_US    = SSC_CLK_HZ / 1_000_000;
  localparam int unsigned SSC_FALL_T0_US    = 131_000;
  localparam int unsigned SSC_FALL_T1_US    = 262_000;
  localparam int unsigned SSC_FALL_T2_US    = 393_000;
  localparam int unsigned SSC_FALL_T3_US    = 524_000;
  localparam int unsigned SSC_RISE_T0_US    = 262_000;
  localparam int unsigned SSC_RISE_T1_US    = 524_000;
  localparam int unsigned SSC_RISE_T2_US    = 786_000;
  localparam int unsigned SSC_RISE_T3_US    = 1_049_000;
  localparam int unsigned SSC_DECAY_T0_US   = 10_000;
  localparam int unsigned SSC_DECAY_T1_US   = 20_000;
  localparam int unsigned SSC_DECAY_T2_US   = 40_000;
  localparam int unsigned SSC_DECAY_T3_US   = 80_000;
  localparam int unsigned SSC_FALL_C0       = SSC_FALL_T0_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_FALL_C1       = SSC_FALL_T1_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_FALL_C2       = SSC_FALL_T2_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_FALL_C3       = SSC_FALL_T3_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_RISE_C0       = SSC_RISE_T0_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_RISE_C1       = SSC_RISE_T1_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_RISE_C2       = SSC_RISE_T2_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_RISE_C3       = SSC_RISE_T3_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_DECAY_C0      = SSC_DECAY_T0_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_DECAY_C1      = SSC_DECAY_T1_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_DECAY_C2      = SSC_DECAY_T2_US * SSC_CYC_PER_US;
  localparam int unsigned SSC_DECAY_C3      = SSC_DECAY_T3_US * SSC_CYC_PER_US;

  // sound effect codes
  typedef enum logic [2:0] {
    SSC_FX_BAR        = 3'b000,
    SSC_FX_BAR_DIM    = 3'b001,
    SSC_FX_RUN        = 3'b010,
    SSC_FX_RUN_DIM    = 3'b011,
    SSC_FX_RGB        = 3'b100,
    SSC_FX_RGB_DIM    = 3'b101,
    SSC_FX_PAR_DIM    = 3'b110,
    SSC_FX_RESERVED   = 3'b111
  } ssc_effect_t;

endpackage : ssc_pkg

// file: logic/ssc_regs.sv
// sound-sync control register bank: four 8-bit registers and derived controls
// assumes the serial control port front end presents single-cycle register
// read/write strobes on clk; level inputs from the analog path are asynchronous
`timescale 1ns/1ps

// Functional notes
// - agc enable bit turns gain control on
// - bit 6 raises gain-up switching threshold
// - bit 5 raises gain-down switching threshold
// - bits 4:3 pick gain fall decay time
// - bits 2:1 pick gain rise decay time
// - bits 5:1 set preamp gain, 1 dB steps
// - bit 0 powers the input buffer
// - bit 6 selects manual capacitor precharge
// - bit 7 inhibits precharge, manual mode only
// - bit 7 routes shared pin or output 4
// - pull-down only when enabled, unpowered, no sound
// - bits 4:3 pick 10 to 80 ms decay
// - codes 0 to 3 select bar effects
// - codes 4, 5 drive outputs 1-3 as colour
// - code 6 parallel dimming; code 7 never used
// - per-output bits choose pattern or sound control
// - automatic gain stays within 3 dB of code
module ssc_regs #(
  parameter int unsigned TIME_DIV = 1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port from the control interface
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // state from the rest of the device, same clock
  input  wire logic       sound_mode_en,
  input  wire logic       auto_precharge_req,
  // level detector outputs from the preamplifier, asynchronous
  input  wire logic       level_above_raise,
  input  wire logic       level_above_lower,
  // gain control
  output logic            agc_active,
  output logic            raise_threshold_hi,
  output logic            lower_threshold_hi,
  output logic      [4:0] preamp_gain_eff,
  output logic            agc_rise_step,
  output logic            agc_fall_step,
  // input stage
  output logic            input_buffer_on,
  output logic            precharge_on,
  output logic            pulldown_on,
  output logic            sound_in_shared_pin,
  output logic            sound_in_out4_pin,
  // effect engine
  output logic            sound_decay_tick,
  output logic      [2:0] effect_mode,
  output logic            effect_dimming,
  output logic            effect_running,
  output logic            effect_colour,
  output logic      [3:0] out_sound_driven
);

  // ---------------- register storage ----------------
  logic [7:0] gain_control_setup_reg;
  logic [7:0] input_buffer_setup_reg;
  logic [7:0] sound_effect_control_reg;
  logic [7:0] output_sound_select_reg;

  logic       wr_gain_w;
  logic       wr_buf_w;
  logic       wr_snd_w;
  logic       wr_out_w;
  logic [7:0] rd_mux_w;

  assign wr_gain_w = reg_wr && (reg_addr == ssc_pkg::SSC_GAIN_CTRL_OFS);
  assign wr_buf_w  = reg_wr && (reg_addr == ssc_pkg::SSC_IN_BUF_OFS);
  assign wr_snd_w  = reg_wr && (reg_addr == ssc_pkg::SSC_SND_CTRL_OFS);
  assign wr_out_w  = reg_wr && (reg_addr == ssc_pkg::SSC_OUT_SEL_OFS);

  // unmapped addresses read back as zero
  assign rd_mux_w =
    (reg_addr == ssc_pkg::SSC_GAIN_CTRL_OFS) ? gain_control_setup_reg   :
    (reg_addr == ssc_pkg::SSC_IN_BUF_OFS)    ? input_buffer_setup_reg   :
    (reg_addr == ssc_pkg::SSC_SND_CTRL_OFS)  ? sound_effect_control_reg :
    (reg_addr == ssc_pkg::SSC_OUT_SEL_OFS)   ? output_sound_select_reg  :
    8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_control_setup_reg   <= ssc_pkg::SSC_GAIN_CTRL_RST;
      input_buffer_setup_reg   <= ssc_pkg::SSC_IN_BUF_RST;
      sound_effect_control_reg <= ssc_pkg::SSC_SND_CTRL_RST;
      output_sound_select_reg  <= ssc_pkg::SSC_OUT_SEL_RST;
    end
    else
    begin
      if (wr_gain_w)
        gain_control_setup_reg <= reg_wdata & ssc_pkg::SSC_GAIN_CTRL_MASK;
      if (wr_buf_w)
        input_buffer_setup_reg <= reg_wdata & ssc_pkg::SSC_IN_BUF_MASK;
      if (wr_snd_w)
        sound_effect_control_reg <= reg_wdata & ssc_pkg::SSC_SND_CTRL_MASK;
      if (wr_out_w)
        output_sound_select_reg <= reg_wdata & ssc_pkg::SSC_OUT_SEL_MASK;
    end
  end

  // read data registered, valid one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= reg_rd ? rd_mux_w : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // ---------------- field extraction ----------------
  logic       agc_en_w;
  logic [1:0] fall_sel_w;
  logic [1:0] rise_sel_w;
  logic [4:0] gain_code_w;
  logic       buf_pwr_w;
  logic       pre_man_w;
  logic       pre_inh_w;
  logic [2:0] fx_w;
  logic [1:0] decay_sel_w;
  logic       pd_dis_w;
  logic       src_sel_w;

  assign agc_en_w    = gain_control_setup_reg[ssc_pkg::SSC_AGC_EN_BIT];
  assign fall_sel_w  = gain_control_setup_reg[ssc_pkg::SSC_FALL_LSB +: 2];
  assign rise_sel_w  = gain_control_setup_reg[ssc_pkg::SSC_RISE_LSB +: 2];
  assign gain_code_w = input_buffer_setup_reg[ssc_pkg::SSC_GAIN_LSB +: 5];
  assign buf_pwr_w   = input_buffer_setup_reg[ssc_pkg::SSC_BUF_PWR_BIT];
  assign pre_man_w   = input_buffer_setup_reg[ssc_pkg::SSC_PRE_MAN_BIT];
  assign pre_inh_w   = input_buffer_setup_reg[ssc_pkg::SSC_PRE_INH_BIT];
  assign fx_w        = sound_effect_control_reg[ssc_pkg::SSC_EFFECT_LSB +: 3];
  assign decay_sel_w = sound_effect_control_reg[ssc_pkg::SSC_DECAY_LSB +: 2];
  assign pd_dis_w    = sound_effect_control_reg[ssc_pkg::SSC_PD_DIS_BIT];
  assign src_sel_w   = sound_effect_control_reg[ssc_pkg::SSC_SRC_SEL_BIT];

  // one of four period counts, scaled by TIME_DIV, used for all three timers
  function automatic logic [31:0] pick4(input logic [1:0] sel,
                                        input int unsigned c0,
                                        input int unsigned c1,
                                        input int unsigned c2,
                                        input int unsigned c3);
    logic [31:0] r;
    r = 32'(c0 / TIME_DIV);
    if (sel == 2'h1)
      r = 32'(c1 / TIME_DIV);
    else if (sel == 2'h2)
      r = 32'(c2 / TIME_DIV);
    else if (sel == 2'h3)
      r = 32'(c3 / TIME_DIV);
    return r;
  endfunction : pick4

  // ---------------- decay timers ----------------
  logic [31:0] fall_period_w;
  logic [31:0] rise_period_w;
  logic [31:0] decay_period_w;
  logic        fall_tick_w;
  logic        rise_tick_w;
  logic        decay_tick_w;

  assign fall_period_w  = pick4(fall_sel_w, ssc_pkg::SSC_FALL_C0, ssc_pkg::SSC_FALL_C1,
                                ssc_pkg::SSC_FALL_C2, ssc_pkg::SSC_FALL_C3);
  assign rise_period_w  = pick4(rise_sel_w, ssc_pkg::SSC_RISE_C0, ssc_pkg::SSC_RISE_C1,
                                ssc_pkg::SSC_RISE_C2, ssc_pkg::SSC_RISE_C3);
  assign decay_period_w = pick4(decay_sel_w, ssc_pkg::SSC_DECAY_C0, ssc_pkg::SSC_DECAY_C1,
                                ssc_pkg::SSC_DECAY_C2, ssc_pkg::SSC_DECAY_C3);

  ssc_tick_gen #(.W(32)) u_fall_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (agc_en_w),
    .period (fall_period_w),
    .tick   (fall_tick_w)
  );

  ssc_tick_gen #(.W(32)) u_rise_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (agc_en_w),
    .period (rise_period_w),
    .tick   (rise_tick_w)
  );

  ssc_tick_gen #(.W(32)) u_decay_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (sound_mode_en),
    .period (decay_period_w),
    .tick   (decay_tick_w)
  );

  // ---------------- level detector synchronisers ----------------
  // a change is taken only once the second and third stages agree
  logic [2:0] raise_sync_reg;
  logic [2:0] lower_sync_reg;
  logic       raise_lvl_reg;
  logic       lower_lvl_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raise_sync_reg <= 3'h0;
      lower_sync_reg <= 3'h0;
      raise_lvl_reg  <= 1'b0;
      lower_lvl_reg  <= 1'b0;
    end
    else
    begin
      raise_sync_reg <= {raise_sync_reg[1:0], level_above_raise};
      lower_sync_reg <= {lower_sync_reg[1:0], level_above_lower};
      if (raise_sync_reg[1] == raise_sync_reg[2])
        raise_lvl_reg <= raise_sync_reg[2];
      if (lower_sync_reg[1] == lower_sync_reg[2])
        lower_lvl_reg <= lower_sync_reg[2];
    end
  end

  // ---------------- automatic gain ----------------
  // offset is relative to the programmed code so a new code restarts the loop
  logic signed [2:0] agc_ofs_reg;
  logic signed [2:0] agc_ofs_next;
  logic              gain_restart_w;

  function automatic logic [4:0] apply_ofs(input logic [4:0] code,
                                           input logic signed [2:0] ofs);
    logic signed [6:0] sum;
    sum = $signed({2'b00, code}) + 7'(ofs);
    if (sum < 7'sd0)
      return 5'h00;
    else if (sum > $signed({2'b00, ssc_pkg::SSC_GAIN_MAX}))
      return ssc_pkg::SSC_GAIN_MAX;
    else
      return sum[4:0];
  endfunction : apply_ofs

  assign gain_restart_w = wr_buf_w || !agc_en_w;

  // below the raise threshold the gain climbs; above the lower one it drops
  always_comb
  begin
    agc_ofs_next = agc_ofs_reg;
    if (fall_tick_w && lower_lvl_reg && (agc_ofs_reg > -ssc_pkg::SSC_AGC_SPAN))
      agc_ofs_next = agc_ofs_reg - 3'sd1;
    else if (rise_tick_w && !raise_lvl_reg && (agc_ofs_reg < ssc_pkg::SSC_AGC_SPAN))
      agc_ofs_next = agc_ofs_reg + 3'sd1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      agc_ofs_reg <= 3'sd0;
    else if (gain_restart_w)
      agc_ofs_reg <= 3'sd0;
    else
      agc_ofs_reg <= agc_ofs_next;
  end

  // ---------------- effect decode ----------------
  logic       fx_dim_w;
  logic       fx_run_w;
  logic       fx_rgb_w;
  logic [3:0] fx_used_w;
  logic       pd_w;
  logic       pre_w;

  assign fx_dim_w = (fx_w == ssc_pkg::SSC_FX_BAR_DIM) || (fx_w == ssc_pkg::SSC_FX_RUN_DIM)
                 || (fx_w == ssc_pkg::SSC_FX_RGB_DIM) || (fx_w == ssc_pkg::SSC_FX_PAR_DIM);
  assign fx_run_w = (fx_w == ssc_pkg::SSC_FX_RUN) || (fx_w == ssc_pkg::SSC_FX_RUN_DIM);
  assign fx_rgb_w = (fx_w == ssc_pkg::SSC_FX_RGB) || (fx_w == ssc_pkg::SSC_FX_RGB_DIM);
  // reserved code drives nothing so a stray write stays dark
  assign fx_used_w = (fx_w == ssc_pkg::SSC_FX_RESERVED) ? 4'h0 :
                     fx_rgb_w ? 4'h7 : 4'hf;
  assign pd_w  = !pd_dis_w && !buf_pwr_w && !sound_mode_en;
  assign pre_w = pre_man_w ? !pre_inh_w : auto_precharge_req;

  // ---------------- registered outputs ----------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      agc_active          <= 1'b0;
      raise_threshold_hi  <= 1'b0;
      lower_threshold_hi  <= 1'b0;
      preamp_gain_eff     <= 5'h00;
      agc_rise_step       <= 1'b0;
      agc_fall_step       <= 1'b0;
      input_buffer_on     <= 1'b0;
      precharge_on        <= 1'b0;
      pulldown_on         <= 1'b0;
      sound_in_shared_pin <= 1'b0;
      sound_in_out4_pin   <= 1'b0;
      sound_decay_tick    <= 1'b0;
      effect_mode         <= 3'h0;
      effect_dimming      <= 1'b0;
      effect_running      <= 1'b0;
      effect_colour       <= 1'b0;
      out_sound_driven    <= 4'h0;
    end
    else
    begin
      agc_active          <= agc_en_w;
      raise_threshold_hi  <= gain_control_setup_reg[ssc_pkg::SSC_RAISE_HI_BIT];
      lower_threshold_hi  <= gain_control_setup_reg[ssc_pkg::SSC_LOWER_HI_BIT];
      preamp_gain_eff     <= apply_ofs(gain_code_w, agc_ofs_reg);
      agc_rise_step       <= rise_tick_w;
      agc_fall_step       <= fall_tick_w;
      input_buffer_on     <= buf_pwr_w;
      precharge_on        <= pre_w;
      pulldown_on         <= pd_w;
      sound_in_shared_pin <= sound_mode_en && !src_sel_w;
      sound_in_out4_pin   <= sound_mode_en && src_sel_w;
      sound_decay_tick    <= decay_tick_w;
      effect_mode         <= fx_w;
      effect_dimming      <= fx_dim_w;
      effect_running      <= fx_run_w;
      effect_colour       <= fx_rgb_w;
      out_sound_driven    <= output_sound_select_reg[3:0] & fx_used_w;
    end
  end

endmodule : ssc_regs

// file: logic/ssc_tick_gen.sv
// periodic one-cycle enable pulse with a selectable period
// assumes period is held steady while run is high; a change restarts nothing
`timescale 1ns/1ps
module ssc_tick_gen #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // pulse
  output logic              tick
);

  logic [W-1:0] cnt_reg;
  logic         last_w;

  assign last_w = (cnt_reg >= period - W'(1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else if (!run)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      cnt_reg <= last_w ? '0 : cnt_reg + W'(1);
      tick    <= last_w;
    end
  end

endmodule : ssc_tick_gen

// file: tb/ssc_regs_checker.sv
// assertions for the sound-sync register bank, bound onto ssc_regs
// assumes one clock domain and sees only the top module ports
`timescale 1ns/1ps
module ssc_regs_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port and sound mode enable
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       sound_mode_en,
  // derived controls
  input wire logic       agc_active,
  input wire logic       raise_threshold_hi,
  input wire logic       lower_threshold_hi,
  input wire logic [4:0] preamp_gain_eff,
  input wire logic       agc_rise_step,
  input wire logic       agc_fall_step,
  input wire logic       input_buffer_on,
  input wire logic       pulldown_on,
  input wire logic       sound_in_shared_pin,
  input wire logic       sound_in_out4_pin,
  input wire logic       sound_decay_tick,
  input wire logic [2:0] effect_mode,
  input wire logic       effect_dimming,
  input wire logic       effect_colour,
  input wire logic [3:0] out_sound_driven
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire logic w_gain = reg_wr && reg_addr == 8'h40;
  wire logic w_buf  = reg_wr && reg_addr == 8'h41;
  wire logic w_snd  = reg_wr && reg_addr == 8'h42;
  wire logic w_out  = reg_wr && reg_addr == 8'h43;
  wire logic par_ok = effect_mode < 3'd4 || effect_mode == 3'd6;

  rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read strobe not answered next cycle");
  rd_quiet_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  agc_follow_a: assert property (w_gain |=> ##1 agc_active == $past(reg_wdata[0], 2))
    else $error("gain control enable not following write");
  thresh_follow_a: assert property (w_gain |=> ##1
    {raise_threshold_hi, lower_threshold_hi} == $past(reg_wdata[6:5], 2))
    else $error("threshold selects not following write");
  buf_follow_a: assert property (w_buf |=> ##1 input_buffer_on == $past(reg_wdata[0], 2))
    else $error("buffer power not following write");
  gain_load_a: assert property (w_buf && !agc_active && !$past(w_gain) |=> ##1
    preamp_gain_eff == $past(reg_wdata[5:1], 2))
    else $error("gain code not applied");
  mode_follow_a: assert property (w_snd |=> ##1 effect_mode == $past(reg_wdata[2:0], 2))
    else $error("effect mode not following write");
  fx_decode_a: assert property ({effect_dimming, effect_colour} ==
    {effect_mode inside {3'd1, 3'd3, 3'd5, 3'd6}, effect_mode inside {3'd4, 3'd5}})
    else $error("effect decode wrong");
  colour_mask_a: assert property (effect_mode[2:1] == 2'b10 |-> !out_sound_driven[3])
    else $error("output 4 used in colour mode");
  reserved_mode_a: assert property (effect_mode == 3'd7 |-> out_sound_driven == 4'h0)
    else $error("outputs driven in reserved mode");
  drv_follow_a: assert property (w_out |=> ##1 par_ok |->
    out_sound_driven == $past(reg_wdata[3:0], 2))
    else $error("output select not following write");
  pulldown_gate_a: assert property (pulldown_on |-> !input_buffer_on && !$past(sound_mode_en))
    else $error("pull-down on while buffered or in sound mode");
  pd_disable_a: assert property (w_snd && reg_wdata[6] |=> ##1 !pulldown_on)
    else $error("pull-down on while disabled");
  src_route_a: assert property ((sound_in_shared_pin || sound_in_out4_pin) |->
    $past(sound_mode_en) && !(sound_in_shared_pin && sound_in_out4_pin))
    else $error("sound source routing wrong");
  decay_idle_a: assert property (!sound_mode_en [*3] |-> !sound_decay_tick)
    else $error("decay tick outside sound mode");
  agc_idle_a: assert property (!agc_active [*3] |-> !agc_rise_step && !agc_fall_step)
    else $error("gain step while gain control off");

  cover property (reg_rvalid && reg_rdata != 8'h00);
  cover property (effect_colour && out_sound_driven == 4'h7);
  cover property (agc_fall_step ##[1:100] agc_rise_step);
endmodule : ssc_regs_checker

bind ssc_regs ssc_regs_checker u_ssc_regs_checker (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sound_mode_en, .agc_active, .raise_threshold_hi,
  .lower_threshold_hi, .preamp_gain_eff, .agc_rise_step, .agc_fall_step, .input_buffer_on,
  .pulldown_on, .sound_in_shared_pin, .sound_in_out4_pin, .sound_decay_tick, .effect_mode,
  .effect_dimming, .effect_colour, .out_sound_driven);

// file: tb/tb_top.sv
// self-checking bench for the sound-sync register bank
// assumes ssc_pkg compiled first; short timer periods keep the run brief
`timescale 1ns/1ps
module tb_top;
  logic       clk;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sound_mode_en = 1'b0;
  logic       auto_precharge_req = 1'b0;
  logic       level_above_raise = 1'b0;
  logic       level_above_lower = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] preamp_gain_eff;
  logic [2:0] effect_mode;
  logic [3:0] out_sound_driven;
  logic       reg_rvalid, agc_active, raise_threshold_hi, lower_threshold_hi;
  logic       agc_rise_step, agc_fall_step, input_buffer_on, precharge_on, pulldown_on;
  logic       sound_in_shared_pin, sound_in_out4_pin, sound_decay_tick;
  logic       effect_dimming, effect_running, effect_colour;
  logic [7:0] rd_q[$];
  logic [7:0] v;
  logic [3:0] dm;
  int         fail_count = 0;
  int         checked = 0;
  int         seed;

  // timer periods shrink to one cycle per millisecond
  localparam int unsigned TD = 25_000;

  ssc_regs #(.TIME_DIV(TD)) u_ssc_regs (.clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sound_mode_en,
    .auto_precharge_req, .level_above_raise, .level_above_lower, .agc_active,
    .raise_threshold_hi, .lower_threshold_hi, .preamp_gain_eff, .agc_rise_step,
    .agc_fall_step, .input_buffer_on, .precharge_on, .pulldown_on, .sound_in_shared_pin,
    .sound_in_out4_pin, .sound_decay_tick, .effect_mode, .effect_dimming, .effect_running,
    .effect_colour, .out_sound_driven);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // one bus cycle per call so back-to-back strobes never clash
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    if (r)
      rd_q.push_back(d);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic idle(input int n);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n) @(negedge clk);
  endtask : idle

  function automatic logic [7:0] msk(input int j);
    return j == 0 ? ssc_pkg::SSC_GAIN_CTRL_MASK : j == 1 ? ssc_pkg::SSC_IN_BUF_MASK :
      j == 2 ? ssc_pkg::SSC_SND_CTRL_MASK : j == 3 ? ssc_pkg::SSC_OUT_SEL_MASK : 8'h00;
  endfunction : msk

  function automatic logic tk(input int s);
    return s == 0 ? sound_decay_tick : s == 1 ? agc_fall_step : agc_rise_step;
  endfunction : tk

  // spacing between two later ticks, so the start-up interval does not count
  task automatic per(input int s, input int p);
    int n;
    n = 0;
    while (tk(s) !== 1'b1 && n < 1100)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (tk(s) !== 1'b1 && n < 1100);
    chk(16'(n), 16'(p), "tick spacing");
  endtask : per

  // read answers, oldest note first
  always @(negedge clk)
    if (reg_rvalid !== 1'b0)
    begin
      if (rd_q.size() == 0)
        chk(16'h1, 16'h0, "answer without read");
      else
        chk({8'h0, reg_rdata}, {8'h0, rd_q.pop_front()}, "read data");
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    seed = 73;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++)
      bus(1'b0, 1'b1, 8'h3f + 8'(i), 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      v = 8'($random(seed));
      for (int j = 0; j < 5; j++)
        wr(8'h40 + 8'(j), v);
      for (int j = 0; j < 5; j++)
        bus(1'b0, 1'b1, 8'h40 + 8'(j), v & msk(j));
      idle(3);
      chk({agc_active, raise_threshold_hi, lower_threshold_hi}, {v[0], v[6:5]}, "agc");
      chk({input_buffer_on, effect_mode}, {v[0], v[2:0]}, "buffer and mode");
    end
    wr(8'h40, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      auto_precharge_req = i[2];
      wr(8'h41, {i[1:0], 6'h00});
      idle(3);
      chk(precharge_on, i[0] ? !i[1] : i[2], "precharge");
      wr(8'h41, 8'h00);
    end
    for (int i = 0; i < 16; i++)
    begin
      sound_mode_en = i[3];
      wr(8'h42, {i[0], i[1], 6'h00});
      wr(8'h41, {7'h00, i[2]});
      idle(3);
      chk({pulldown_on, sound_in_shared_pin, sound_in_out4_pin},
        {!i[1] && !i[2] && !i[3], i[3] && !i[0], i[3] && i[0]}, "pin routing");
    end
    for (int m = 0; m < 8; m++)
    begin
      v = 8'($random(seed));
      dm = m == 7 ? 4'h0 : (m == 4 || m == 5) ? 4'h7 : 4'hf;
      wr(8'h43, v);
      wr(8'h42, 8'(m));
      idle(3);
      chk({effect_mode, effect_dimming, effect_running, effect_colour, out_sound_driven},
        {3'(m), m == 1 || m == 3 || m == 5 || m == 6, m == 2 || m == 3, m == 4 || m == 5,
        v[3:0] & dm}, "effect decode");
    end
    for (int c = 0; c < 4; c++)
    begin
      sound_mode_en = 1'b0;
      wr(8'h42, 8'(c << 3));
      idle(2);
      sound_mode_en = 1'b1;
      per(0, (ssc_pkg::SSC_DECAY_C0 << c) / TD);
      wr(8'h40, 8'h00);
      wr(8'h40, 8'((c << 3) | (c << 1) | 1));
      per(1, ssc_pkg::SSC_FALL_C0 * (c + 1) / TD);
      per(2, (c == 3 ? ssc_pkg::SSC_RISE_C3 : ssc_pkg::SSC_RISE_C0 * (c + 1)) / TD);
    end
    sound_mode_en = 1'b0;
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h21);
    level_above_lower = 1'b1;
    level_above_raise = 1'b1;
    wr(8'h40, 8'h01);
    idle(450);
    chk(preamp_gain_eff, 5'd13, "gain floor");
    level_above_lower = 1'b0;
    level_above_raise = 1'b0;
    idle(1500);
    chk(preamp_gain_eff, 5'd19, "gain ceiling");
    wr(8'h40, 8'h00);
    idle(3);
    chk(preamp_gain_eff, 5'd16, "gain restored");
    chk(16'(rd_q.size()), 16'h0, "reads unanswered");
    report_and_stop();
  end
endmodule : tb_top
